/* File: core/csu_acc_store.sv */
/*
 * Accumulator store: four words with a registered read port.
 * Assumes the sequencer holds the read select one cycle ahead of use.
 */
`timescale 1ns/1ps
module csu_acc_store
	import csu_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	csu_acc_if.store acc,
	output logic [ACC_NUM*DATA_W-1:0] accFlat
);
	logic [DATA_W-1:0] mem_ff [ACC_NUM];
	logic [DATA_W-1:0] rd_ff;

	// Word storage
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < ACC_NUM; i++) begin
				mem_ff[i] <= ACC_RESET;
			end
		end else if (acc.wrEn) begin
			mem_ff[acc.wrSel] <= acc.wrData;
		end
	end

	// Registered read, bypassing a same-cycle write
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rd_ff <= ACC_RESET;
		end else if (acc.wrEn && acc.wrSel == acc.rdSel) begin
			rd_ff <= acc.wrData;
		end else begin
			rd_ff <= mem_ff[acc.rdSel];
		end
	end

	assign acc.rdData = rd_ff;

	// Flat view for observation
	always_comb begin
		for (int i = 0; i < ACC_NUM; i++) begin
			accFlat[i*DATA_W +: DATA_W] = mem_ff[i];
		end
	end
endmodule : csu_acc_store

/* File: core/csu_shift_unit.sv */
/*
 * Shift unit of the CPU datapath: shifts, carry set and display fill call.
 * Assumes the decoder issues one operation pulse while busy is low.
 */
`timescale 1ns/1ps
module csu_shift_unit
	import csu_pkg::*;
#(
	parameter int CW = CNT_W
)(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic opValid,
	input wire logic [3:0] opCode,
	input wire logic [ACC_SEL_W-1:0] accumulatorOperand,
	input wire logic countPresent,
	input wire logic [CW-1:0] countValue,
	input wire logic accLoadEn,
	input wire logic [DATA_W-1:0] accLoadData,
	output logic busy,
	output logic opDone,
	output logic [1:0] opBytes,
	output logic carry,
	output logic overflow,
	output logic sign,
	output logic zero,
	output logic [ACC_NUM*DATA_W-1:0] accFlat,
	output logic romCall,
	output logic [ROM_ADDR_W-1:0] romCallAddr,
	output logic dispWrEn,
	output logic [DISP_ADDR_W-1:0] dispWrAddr,
	output logic [DATA_W-1:0] dispWrData
);
	csu_acc_if acc ();
	csu_state_e state_ff;
	logic [CW-1:0] remain_ff;
	logic isLeft_ff;
	logic [ACC_SEL_W-1:0] sel_ff;
	logic [DATA_W-1:0] work_ff;
	logic haveWork_ff;
	logic carry_ff;
	logic ovf_ff;
	logic sign_ff;
	logic zero_ff;
	logic argWait_ff;
	logic loadNow;
	logic startShift;
	logic startSetc;
	logic startFill;
	logic stepNow;
	logic done_ff;
	logic [1:0] bytes_ff;
	logic fillSecond_ff;
	logic dispEn_ff;
	logic [DISP_ADDR_W-1:0] dispAddr_ff;
	logic [DATA_W-1:0] stepVal;
	logic stepOut;
	logic [DATA_W-1:0] srcVal;
	logic lastStep;
	logic start;

	csu_acc_store u_store (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.acc(acc),
		.accFlat(accFlat)
	);

	// One shift step, left logical or right arithmetic
	function automatic logic [DATA_W:0] shiftStep(input logic left,
		input logic [DATA_W-1:0] v);
		if (left) begin
			shiftStep = {v[DATA_W-1], v[DATA_W-2:0], 1'b0};
		end else begin
			shiftStep = {v[0], v[DATA_W-1], v[DATA_W-1:1]};
		end
	endfunction : shiftStep

	// Opcode classes that run the shift sequencer
	function automatic logic isShiftOp(input logic [3:0] op);
		isShiftOp = op == OP_SHL || op == OP_SAR;
	endfunction : isShiftOp

	// Issue decode
	assign start = opValid && state_ff == ST_IDLE;
	assign startShift = start && isShiftOp(opCode);
	assign startSetc = start && opCode == OP_CARRY_SET_OP;
	assign startFill = start && opCode == OP_FILL;
	assign busy = state_ff != ST_IDLE;
	// A load from the register file side is taken only while idle and
	// no operation is issued, so it never races a shift write-back
	assign loadNow = accLoadEn && state_ff == ST_IDLE && !opValid;
	assign acc.rdSel = start ? accumulatorOperand : sel_ff;
	// First step uses the freshly read word, later steps the held result
	assign srcVal = haveWork_ff ? work_ff : acc.rdData;
	assign {stepOut, stepVal} = shiftStep(isLeft_ff, srcVal);
	// The count byte costs one cycle before the first step
	assign stepNow = state_ff == ST_SHIFT && !argWait_ff;
	assign lastStep = stepNow && remain_ff <= CW'(1);
	// One write port shared by the shift write-back and operand loads
	assign acc.wrEn = lastStep || loadNow;
	assign acc.wrSel = lastStep ? sel_ff : accumulatorOperand;
	assign acc.wrData = lastStep ? stepVal : accLoadData;

	// Sequencer; the accumulator read overlaps the issue cycle, so a
	// plain shift is busy one cycle and a count of p 1 + p cycles
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_IDLE;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (startShift) begin
						state_ff <= ST_SHIFT;
					end else if (startFill) begin
						state_ff <= ST_FILL;
					end
				end
				ST_SHIFT: begin
					if (lastStep) begin
						state_ff <= ST_IDLE;
					end
				end
				ST_FILL: begin
					if (fillSecond_ff) begin
						state_ff <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Operand capture and repeat counting
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			remain_ff <= '0;
			isLeft_ff <= 1'b0;
			sel_ff <= '0;
			haveWork_ff <= 1'b0;
			work_ff <= ACC_RESET;
		end else if (start) begin
			// Absent count means one step; zero count is taken as one
			remain_ff <= (countPresent && countValue != '0) ?
				countValue : CW'(1);
			isLeft_ff <= opCode == OP_SHL;
			sel_ff <= accumulatorOperand;
			haveWork_ff <= 1'b0;
		end else if (stepNow) begin
			remain_ff <= remain_ff - CW'(1);
			work_ff <= stepVal;
			haveWork_ff <= 1'b1;
		end
	end

	// Count byte fetch: a counted shift waits one cycle before stepping
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			argWait_ff <= 1'b0;
		end else if (startShift) begin
			argWait_ff <= countPresent;
		end else begin
			argWait_ff <= 1'b0;
		end
	end

	// Carry: forced by carry set, else the bit leaving each step
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			carry_ff <= 1'b0;
		end else if (startSetc) begin
			carry_ff <= 1'b1;
		end else if (stepNow) begin
			carry_ff <= stepOut;
		end
	end

	// Overflow: cleared by carry set, else a sign change in the step
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ovf_ff <= 1'b0;
		end else if (startSetc) begin
			ovf_ff <= 1'b0;
		end else if (stepNow) begin
			ovf_ff <= srcVal[DATA_W-1] ^ stepVal[DATA_W-1];
		end
	end

	// Sign follows the top bit of each step's result
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sign_ff <= 1'b0;
		end else if (stepNow) begin
			sign_ff <= stepVal[DATA_W-1];
		end
	end

	// Zero marks an all-clear step result
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			zero_ff <= 1'b0;
		end else if (stepNow) begin
			zero_ff <= stepVal == '0;
		end
	end

	// Completion pulse and instruction length
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			done_ff <= 1'b0;
			bytes_ff <= 2'h0;
		end else begin
			done_ff <= lastStep || (state_ff == ST_FILL && fillSecond_ff)
				|| startSetc;
			if (start) begin
				bytes_ff <= (countPresent && isShiftOp(opCode)) ?
					LEN_LONG : LEN_SHORT;
			end
		end
	end

	// Display fill routine: two all-ones writes after the ROM call
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fillSecond_ff <= 1'b0;
			dispEn_ff <= 1'b0;
			dispAddr_ff <= '0;
		end else if (state_ff == ST_FILL) begin
			fillSecond_ff <= ~fillSecond_ff;
			dispEn_ff <= 1'b1;
			dispAddr_ff <= fillSecond_ff ? DISP_REG_B : DISP_REG_A;
		end else begin
			fillSecond_ff <= 1'b0;
			dispEn_ff <= 1'b0;
		end
	end

	assign opDone = done_ff;
	assign opBytes = bytes_ff;
	assign carry = carry_ff;
	assign overflow = ovf_ff;
	assign sign = sign_ff;
	assign zero = zero_ff;
	assign romCall = startFill;
	assign romCallAddr = FILL_ROUTINE_ADDR;
	assign dispWrEn = dispEn_ff;
	assign dispWrAddr = dispAddr_ff;
	assign dispWrData = DISP_FILL;
endmodule : csu_shift_unit

/* File: inc/csu_acc_if.sv */
/*
 * Port bundle between the shift sequencer and the accumulator store.
 * Assumes one write per cycle and a registered read.
 */
`timescale 1ns/1ps
interface csu_acc_if;
	import csu_pkg::*;
	logic [ACC_SEL_W-1:0] rdSel;
	logic [DATA_W-1:0] rdData;
	logic wrEn;
	logic [ACC_SEL_W-1:0] wrSel;
	logic [DATA_W-1:0] wrData;
	modport ctrl (output rdSel, input rdData, output wrEn, wrSel, wrData);
	modport store (input rdSel, output rdData, input wrEn, wrSel, wrData);
endinterface : csu_acc_if

/* File: inc/csu_pkg.sv */
/*
 * Shared constants and types for the CPU shift unit.
 * Assumes a 24-bit datapath with four accumulators and a ROM routine table.
 */
// Functional notes
// - A one-step left shift moves every bit up, puts zero in bit 0 and sends the old top bit to carry.
// - With a count, the left shift repeats that many times and carry holds the last bit shifted out.
// - Both shifts take any of the four accumulators and an optional 4-bit count, defaulting to one.
// - A shift without a count is one byte and one cycle; with a count it is two bytes and 1 plus count cycles.
// - The right shift is arithmetic, moving bits down and copying the sign bit into the top.
// - With a count, the arithmetic right shift repeats that many times, copying the sign bit each step.
// - The carry-set operation sets carry, clears overflow and leaves the accumulators alone.
// - The display-fill operation writes all ones into display registers 61 and 62.
// - The display-fill operation is a call into a ROM routine, costing that routine's cycles.
package csu_pkg;
	localparam int DATA_W = 24;
	localparam int ACC_NUM = 4;
	localparam int ACC_SEL_W = 2;
	localparam int CNT_W = 4;
	localparam int DISP_ADDR_W = 8;
	localparam logic [DISP_ADDR_W-1:0] DISP_REG_A = 8'h3D; // Address 61
	localparam logic [DISP_ADDR_W-1:0] DISP_REG_B = 8'h3E; // Address 62
	localparam int ROM_ADDR_W = 12;
	localparam logic [ROM_ADDR_W-1:0] FILL_ROUTINE_ADDR = 12'h000;
	localparam logic [1:0] LEN_SHORT = 2'h1;
	localparam logic [1:0] LEN_LONG = 2'h2;
	localparam logic [DATA_W-1:0] ACC_RESET = 24'h000000;
	localparam logic [DATA_W-1:0] DISP_FILL = 24'hFFFFFF;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_SHL = 4'h1,
		OP_SAR = 4'h2,
		OP_CARRY_SET_OP = 4'h3,
		OP_FILL = 4'h4
	} csu_op_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_FILL = 3'b100
	} csu_state_e;
endpackage : csu_pkg

/* File: test/cpu_shift_unit_bench.sv */
/* Self-checking bench for the shift unit.
   Assumes csu_dec_model drives the operation inputs. */
`timescale 1ns/1ps
`define CHK(nm, e, a) \
	comparisons++; \
	if ((a) !== (e)) begin \
		failures++; \
		$display("[ERR] %s exp %0h got %0h", nm, e, a); \
	end
module cpu_shift_unit_bench
	import csu_pkg::*;
;
	logic ref_clk, resetn, opValid, countPresent, busy, opDone;
	logic carry, overflow, sign, zero, dispWrEn;
	logic [3:0] opCode;
	logic [ACC_SEL_W-1:0] accOp;
	logic [CNT_W-1:0] countValue;
	logic [1:0] opBytes;
	logic [ACC_NUM*DATA_W-1:0] accFlat;
	logic [DISP_ADDR_W-1:0] dispWrAddr;
	logic [DATA_W-1:0] dispWrData;
	logic accLoadEn, romCall;
	logic [DATA_W-1:0] accLoadData;
	logic [ROM_ADDR_W-1:0] romCallAddr;
	logic [ACC_NUM*DATA_W-1:0] accExp = '0;
	int romCalls = 0;
	int dispWrites = 0;
	int failures = 0;
	int comparisons = 0;
	int n;
	// 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	csu_shift_unit u_dut (.ref_clk, .resetn, .opValid, .opCode,
		.accumulatorOperand(accOp), .countPresent, .countValue,
		.accLoadEn, .accLoadData, .busy,
		.opDone, .opBytes, .carry, .overflow, .sign, .zero, .accFlat,
		.romCall, .romCallAddr, .dispWrEn, .dispWrAddr, .dispWrData);
	csu_dec_model u_dec (.ref_clk, .opValid, .opCode, .accOp,
		.countPresent, .countValue, .accLoadEn, .accLoadData);
	// Counts routine calls and display writes as they stand at each edge
	always @(posedge ref_clk) begin
		if (romCall && romCallAddr == FILL_ROUTINE_ADDR)
			romCalls++;
		if (dispWrEn)
			dispWrites++;
	end
	// Counts and verdict
	task automatic summarize;
		$display("checks %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	// Cycles from issue edge to done, bounded
	task automatic wait_done;
		n = 0;
		#1;
		while (opDone !== 1'b1 && n < 40) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n >= 40) begin
			failures++;
			summarize();
		end
	endtask : wait_done
	// Carry set forces flags and keeps accumulators
	task automatic t_carry_set_op;
		u_dec.issue(4'h3, 2'h0, 1'b0, 4'h0);
		wait_done();
		`CHK("carry_set_op carry", 1'b1, carry)
		`CHK("carry_set_op ovf", 1'b0, overflow)
		`CHK("carry_set_op acc", accExp, accFlat)
		$display("carry_set_op end");
	endtask : t_carry_set_op
	// Load, carry set, then shift: result, flags, timing, length
	task automatic t_shift(input logic [3:0] op, input logic [1:0] acc,
		input logic cp, input logic [3:0] cv, input int cyc,
		input logic [DATA_W-1:0] v, input logic [DATA_W-1:0] r,
		input logic [1:0] co);
		u_dec.load(acc, v);
		accExp[acc*DATA_W +: DATA_W] = v;
		t_carry_set_op();
		u_dec.issue(op, acc, cp, cv);
		wait_done();
		accExp[acc*DATA_W +: DATA_W] = r;
		`CHK("cycles", cyc, n)
		`CHK("bytes", cp ? 2'h2 : 2'h1, opBytes)
		`CHK("carry", co[1], carry)
		`CHK("ovf", co[0], overflow)
		`CHK("zero", r == '0, zero)
		`CHK("sign", r[DATA_W-1], sign)
		`CHK("acc", accExp, accFlat)
		$display("shift %0h count %0d end", op, cv);
	endtask : t_shift
	// Display fill ends on the second register
	task automatic t_fill;
		u_dec.issue(4'h4, 2'h0, 1'b0, 4'h0);
		wait_done();
		`CHK("fill cycles", 2, n)
		`CHK("fill addr", 8'h3E, dispWrAddr)
		`CHK("fill data", 24'hFFFFFF, dispWrData)
		@(posedge ref_clk);
		#1;
		`CHK("fill calls", 1, romCalls)
		`CHK("fill writes", 2, dispWrites)
		$display("fill end");
	endtask : t_fill
	// Main sequence
	initial begin
		resetn = 1'b0;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		t_shift(4'h1, 2'h1, 1'b0, 4'h0, 1, 24'h800001, 24'h000002, 2'h3);
		t_shift(4'h2, 2'h3, 1'b1, 4'h3, 4, 24'h800014, 24'hF00002, 2'h2);
		t_shift(4'h1, 2'h2, 1'b1, 4'h0, 2, 24'h400000, 24'h800000, 2'h1);
		t_shift(4'h2, 2'h0, 1'b1, 4'hF, 16, 24'h004000, 24'h000000, 2'h2);
		t_fill();
		summarize();
	end
endmodule : cpu_shift_unit_bench

/* File: test/csu_dec_model.sv */
/* Decoder model: issues one operation pulse at a time.
   Assumes the caller waits until the previous one is done. */
`timescale 1ns/1ps
module csu_dec_model
	import csu_pkg::*;
(
	input wire logic ref_clk,
	output logic opValid,
	output logic [3:0] opCode,
	output logic [ACC_SEL_W-1:0] accOp,
	output logic countPresent,
	output logic [CNT_W-1:0] countValue,
	output logic accLoadEn,
	output logic [DATA_W-1:0] accLoadData
);
	// Idle values at time zero
	initial begin
		opValid = 1'b0;
		opCode = 4'h0;
		accOp = 2'h0;
		countPresent = 1'b0;
		countValue = 4'h0;
		accLoadEn = 1'b0;
		accLoadData = '0;
	end
	// One-cycle accumulator write from the register file side
	task automatic load(input logic [1:0] acc, input logic [DATA_W-1:0] v);
		@(posedge ref_clk);
		accLoadEn <= 1'b1;
		accOp <= acc;
		accLoadData <= v;
		@(posedge ref_clk);
		accLoadEn <= 1'b0;
	endtask : load
	// One-cycle issue; operands scrambled once taken
	task automatic issue(input logic [3:0] op, input logic [1:0] acc,
		input logic cp, input logic [CNT_W-1:0] cv);
		@(posedge ref_clk);
		opValid <= 1'b1;
		opCode <= op;
		accOp <= acc;
		countPresent <= cp;
		countValue <= cv;
		@(posedge ref_clk);
		opValid <= 1'b0;
		accOp <= ~acc;
		countPresent <= ~cp;
		countValue <= ~cv;
	endtask : issue
endmodule : csu_dec_model

/* File: test/csu_shift_chk.sv */
/* Checker on the shift unit top ports.
   Bound to csu_shift_unit, one clock domain. */
`timescale 1ns/1ps
module csu_shift_chk
	import csu_pkg::*;
#(
	parameter int CW = CNT_W
)(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic opValid,
	input wire logic [3:0] opCode,
	input wire logic [ACC_SEL_W-1:0] accumulatorOperand,
	input wire logic countPresent,
	input wire logic [CW-1:0] countValue,
	input wire logic busy,
	input wire logic opDone,
	input wire logic [1:0] opBytes,
	input wire logic carry,
	input wire logic overflow,
	input wire logic sign,
	input wire logic zero,
	input wire logic [ACC_NUM*DATA_W-1:0] accFlat,
	input wire logic romCall,
	input wire logic [ROM_ADDR_W-1:0] romCallAddr,
	input wire logic dispWrEn,
	input wire logic [DISP_ADDR_W-1:0] dispWrAddr,
	input wire logic [DATA_W-1:0] dispWrData
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Decoded issue conditions
	wire shOp = opValid && !busy && (opCode == 4'h1 || opCode == 4'h2);
	wire scOp = opValid && !busy && opCode == 4'h3;
	// Target of the shift in progress
	logic [ACC_SEL_W-1:0] sel_ff;
	always_ff @(posedge ref_clk) begin
		if (shOp)
			sel_ff <= accumulatorOperand;
	end
	a_carry_set_op_flags: assert property (scOp |=> carry && !overflow)
		else $error("carry set flags wrong");
	a_carry_set_op_acc: assert property (scOp |=> $stable(accFlat))
		else $error("carry set touched accumulators");
	a_shift_single: assert property (shOp && !countPresent
		|=> busy ##1 !busy && opDone) else $error("single shift timing");
	a_shift_three: assert property (shOp && countPresent
		&& countValue == 3 |=> busy[*4] ##1 !busy && opDone)
		else $error("counted shift timing");
	a_shift_len: assert property (shOp
		|=> opBytes == ($past(countPresent) ? 2'h2 : 2'h1))
		else $error("shift length wrong");
	a_zero_flags: assert property (opDone && $past(busy) && !dispWrEn
		|-> zero == (accFlat[sel_ff*DATA_W +: DATA_W] == '0)
		&& sign == accFlat[sel_ff*DATA_W+DATA_W-1])
		else $error("flags after shift");
	a_fill_pair: assert property (romCall |-> ##2 dispWrEn
		&& dispWrAddr == 8'h3D ##1 dispWrEn && dispWrAddr == 8'h3E)
		else $error("display fill writes wrong");
	a_fill_ones: assert property (dispWrEn |-> dispWrData == 24'hFFFFFF)
		else $error("display fill data wrong");
	a_rom_call: assert property (romCall |-> romCallAddr == 12'h000)
		else $error("routine address wrong");
	// Main scenarios reached
	c_carry_set_op: cover property (scOp);
	c_fill: cover property (romCall);
	c_count: cover property (shOp && countPresent);
endmodule : csu_shift_chk
bind csu_shift_unit csu_shift_chk #(.CW(CW)) u_chk (.ref_clk, .resetn,
	.opValid, .opCode, .accumulatorOperand, .countPresent, .countValue,
	.busy, .opDone,
	.opBytes, .carry, .overflow, .sign, .zero, .accFlat, .romCall,
	.romCallAddr, .dispWrEn, .dispWrAddr, .dispWrData);
